// ---- verilog/swm_pkg.sv ----
// Package with constants, types and command codes for the segmented waveform player.
package swm_pkg;

  localparam int SWM_SAMPLE_W   = 16;
  localparam int SWM_LEGACY_W   = 12;
  localparam int SWM_LEGACY_SHL = 4;
  localparam int SWM_ADDR_W     = 20;
  localparam int SWM_SEG_W      = 14;
  localparam int SWM_LEN_W      = 21;
  localparam int SWM_FIFO_DEPTH = 16;

  localparam logic [1:0] SWM_GRAN_LEGACY = 2'h1;
  localparam logic [1:0] SWM_GRAN_MODERN = 2'h3;

  localparam int SWM_CLK_HZ        = 25000000;
  localparam int SWM_RATE_MAX_SPS  = 250000000;
  localparam int SWM_RATE_LEG_SPS  = 100000000;
  localparam int SWM_RATE_MIN_MSPS = 100;
  localparam int SWM_DIV_W         = 32;

  typedef enum logic [2:0] {
    SWM_CMD_NOP     = 3'h0,
    SWM_CMD_DEFINE  = 3'h1,
    SWM_CMD_DELETE  = 3'h2,
    SWM_CMD_DEL_ALL = 3'h3,
    SWM_CMD_SELECT  = 3'h4,
    SWM_CMD_TABLE   = 3'h5,
    SWM_CMD_LOAD    = 3'h6
  } swm_cmd_e;

  typedef struct packed {
    swm_cmd_e                cmd;
    logic [SWM_SEG_W:0]      seg;
    logic [SWM_LEN_W-1:0]    len;
    logic [SWM_ADDR_W-1:0]   base;
  } swm_cmd_s;

  typedef struct packed {
    logic                    vld;
    logic [SWM_ADDR_W-1:0]   base;
    logic [SWM_LEN_W-1:0]    len;
  } swm_seg_s;

  typedef enum logic [1:0] {
    SWM_ST_IDLE = 2'h0,
    SWM_ST_LOAD = 2'h1,
    SWM_ST_DONE = 2'h2
  } swm_ld_e;

endpackage

// ---- verilog/swm_fifo.sv ----
// Parameterised valid/ready FIFO used in the sample download path.
`timescale 1ns/10ps
module swm_fifo
  import swm_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             flush
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wp_q;
  logic [AW:0]      rp_q;
  wire              full_w  = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  wire              empty_w = (wp_q == rp_q);
  wire              push_w  = in_valid && !full_w;
  wire              pop_w   = out_ready && !empty_w;

  assign in_ready  = !full_w;
  assign out_valid = !empty_w;
  assign out_data  = mem_q[rp_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push_w) begin
      mem_q[wp_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
    end else if (flush) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_q + (AW+1)'(push_w);
      rp_q <= rp_q + (AW+1)'(pop_w);
    end
  end
endmodule // swm_fifo

// ---- verilog/swm_player.sv ----
// Segmented waveform memory with partition table, download path and playback.
//
// Behaviour
// - Every sample is stored and played as a 16-bit word.
// - Legacy 12-bit samples are widened by a left shift of four.
// - Sample memory holds 1 M points by default, addresses start at zero.
// - Playback fetches one sample per rate-gate tick from segment start to its end.
// - Sample rate programmable up to 250 MS/s with legacy mode off.
// - Up to 16,384 segments, numbered 1 to 16,384.
// - A definition carries number and length, accepted in any order.
// - Redefining an already defined segment's length is refused.
// - Segment numbers and lengths cannot be read back.
// - A whole partition table entry set applies boundaries directly.
// - Deleting a segment unlinks it and leaves its samples intact.
// - New segments go at the table end; deleting the last rewinds it.
// - Clearing the table keeps samples so a reload restores access.
// - Downloads are taken only with an active segment, into it alone.
// - The active segment plays the next time output is enabled.
// - The sync pulse marks the active segment's start.
// - Each full-length download overwrites the targeted segment; a short one flags an error.
// - Input resolution is selectable as 12 or 16 bits.
// - Legacy mode caps rate at 100 MS/s, length multiple of 2; resolution is set separately.
// - Legacy mode is switched by command with a build-dependent default.
// - Outside legacy mode lengths must be multiples of four, else error.
`timescale 1ns/10ps
module swm_player
  import swm_pkg::*;
#(
  parameter int          ADDR_W     = SWM_ADDR_W,
  parameter int          SEG_W      = SWM_SEG_W,
  parameter int          FIFO_DEPTH = SWM_FIFO_DEPTH,
  parameter logic        LEGACY_DEF = 1'b1,
  parameter logic        RES12_DEF  = 1'b1
) (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire swm_cmd_s                 cmd,
  input  wire logic                     cmd_valid,
  input  wire logic [SWM_SAMPLE_W-1:0]  dl_data,
  input  wire logic                     dl_valid,
  input  wire logic                     dl_last,
  input  wire logic                     legacy_set,
  input  wire logic                     legacy_val,
  input  wire logic                     res_set,
  input  wire logic                     res12_val,
  input  wire logic [SWM_DIV_W-1:0]     rate_sps,
  input  wire logic                     out_en,
  output logic                          dl_ready,
  output logic [SWM_SAMPLE_W-1:0]       wave_out,
  output logic                          wave_valid,
  output logic                          sync_out,
  output logic                          err_q,
  output logic                          legacy_q,
  output logic                          res12_q,
  output logic                          active_vld_q,
  output logic                          busy_q
);
  localparam int DEPTH = 1 << ADDR_W;
  localparam int NSEG  = 1 << SEG_W;
  localparam int RATE_CLK_W = SWM_DIV_W;

  logic rst_s1_q, rst_n;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // Segment number n lives at table index n-1 so the full 16,384 fit in 14 bits.
  logic [SWM_SAMPLE_W-1:0] mem_q [DEPTH];
  // The host can only write the table; there is no path that reads it back out.
  swm_seg_s                tab_q [NSEG];
  logic [ADDR_W:0]         tail_q;
  logic [SEG_W-1:0]        last_def_q;
  logic                    last_def_vld_q;
  logic [SEG_W-1:0]        act_q;
  swm_ld_e                 ld_q;
  logic [SWM_LEN_W-1:0]    ld_cnt_q;
  logic [ADDR_W-1:0]       pb_addr_q;
  logic [SWM_LEN_W-1:0]    pb_cnt_q;
  logic                    out_en_q;
  logic [RATE_CLK_W-1:0]   phase_q;

  wire [SEG_W:0]     cnum_w    = cmd.seg - (SEG_W+1)'(1);
  wire [SEG_W-1:0]   cidx_w    = cnum_w[SEG_W-1:0];
  wire               cseg_ok_w = (cmd.seg != '0) && (cmd.seg <= (SEG_W+1)'(NSEG));
  swm_seg_s          cent_w;
  assign cent_w = tab_q[cidx_w];
  wire [1:0]         gran_w    = legacy_q ? SWM_GRAN_LEGACY : SWM_GRAN_MODERN;
  wire               len_ok_w  = (cmd.len != '0) && ((cmd.len[1:0] & gran_w) == 2'h0);
  wire [ADDR_W+1:0]  room_w    = {1'b0, tail_q} + (ADDR_W+2)'(cmd.len);
  wire               fits_w    = room_w <= (ADDR_W+2)'(DEPTH);
  wire               is_def_w  = cmd_valid && cmd.cmd == SWM_CMD_DEFINE;
  wire               is_tab_w  = cmd_valid && cmd.cmd == SWM_CMD_TABLE;
  wire               is_del_w  = cmd_valid && cmd.cmd == SWM_CMD_DELETE;
  wire               is_all_w  = cmd_valid && cmd.cmd == SWM_CMD_DEL_ALL;
  wire               is_sel_w  = cmd_valid && cmd.cmd == SWM_CMD_SELECT;
  wire               is_load_w = cmd_valid && cmd.cmd == SWM_CMD_LOAD;
  wire               def_ok_w  = is_def_w && cseg_ok_w && !cent_w.vld && len_ok_w && fits_w;
  wire               tab_ok_w  = is_tab_w && cseg_ok_w && len_ok_w
                                 && ((ADDR_W+2)'(cmd.base) + (ADDR_W+2)'(cmd.len)
                                     <= (ADDR_W+2)'(DEPTH));
  wire               sel_ok_w  = is_sel_w && cseg_ok_w && cent_w.vld;
  wire               load_ok_w = is_load_w && active_vld_q && ld_q == SWM_ST_IDLE;
  wire               bad_cmd_w = (is_def_w && !def_ok_w) || (is_tab_w && !tab_ok_w)
                                 || (is_sel_w && !sel_ok_w) || (is_load_w && !load_ok_w);
  wire               del_last_w = is_del_w && cseg_ok_w && last_def_vld_q
                                  && cidx_w == last_def_q && cent_w.vld;

  // Download samples pass a FIFO; dl_ready holds the host off unless a download is running and the FIFO has room.
  wire [SWM_SAMPLE_W-1:0] wide_w = res12_q
    ? {dl_data[SWM_LEGACY_W-1:0], SWM_LEGACY_SHL'(0)} : dl_data;
  logic                   f_valid, f_ready_in, f_last;
  logic [SWM_SAMPLE_W:0]  f_data;
  wire                    f_pop_w = (ld_q == SWM_ST_LOAD) && f_valid;
  swm_fifo #(.WIDTH(SWM_SAMPLE_W+1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (dl_valid && dl_ready && ld_q == SWM_ST_LOAD),
    .in_ready  (f_ready_in),
    .in_data   ({dl_last, wide_w}),
    .out_valid (f_valid),
    .out_ready (f_pop_w),
    .out_data  (f_data),
    .flush     (ld_q == SWM_ST_IDLE)
  );
  assign f_last = f_data[SWM_SAMPLE_W];

  swm_seg_s          act_ent_w;
  assign act_ent_w = tab_q[act_q];
  wire [SWM_LEN_W-1:0] ld_next_w = ld_cnt_q + SWM_LEN_W'(1);
  wire ld_over_w  = f_pop_w && (ld_cnt_q >= act_ent_w.len);
  wire ld_short_w = f_pop_w && f_last && (ld_next_w != act_ent_w.len);
  wire ld_end_w   = f_pop_w && f_last;
  wire ld_wr_w    = f_pop_w && !ld_over_w;

  // Writes land directly in the active segment; a bad count aborts with an error flag.
  always_ff @(posedge clk) begin
    if (ld_wr_w) begin
      mem_q[act_ent_w.base + ADDR_W'(ld_cnt_q)] <= f_data[SWM_SAMPLE_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ld_q     <= SWM_ST_IDLE;
      ld_cnt_q <= '0;
    end else begin
      case (ld_q)
        SWM_ST_IDLE: begin
          ld_cnt_q <= '0;
          if (load_ok_w) begin
            ld_q <= SWM_ST_LOAD;
          end
        end
        SWM_ST_LOAD: begin
          if (f_pop_w) begin
            ld_cnt_q <= ld_next_w;
          end
          if (ld_end_w || ld_over_w) begin
            ld_q <= SWM_ST_DONE;
          end
        end
        default: begin
          ld_q <= SWM_ST_IDLE;
        end
      endcase
    end
  end

  // Table entries are only ever cleared logically, never the sample memory.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NSEG; i++) begin
        tab_q[i] <= '0;
      end
      tail_q         <= '0;
      last_def_q     <= '0;
      last_def_vld_q <= 1'b0;
    end else if (ld_q == SWM_ST_IDLE) begin
      if (is_all_w) begin
        for (int i = 0; i < NSEG; i++) begin
          tab_q[i].vld <= 1'b0;
        end
        tail_q         <= '0;
        last_def_vld_q <= 1'b0;
      end else if (def_ok_w) begin
        tab_q[cidx_w]  <= '{vld: 1'b1, base: tail_q[ADDR_W-1:0], len: cmd.len};
        tail_q         <= room_w[ADDR_W:0];
        last_def_q     <= cidx_w;
        last_def_vld_q <= 1'b1;
      end else if (tab_ok_w) begin
        tab_q[cidx_w] <= '{vld: 1'b1, base: cmd.base, len: cmd.len};
        if ((ADDR_W+1)'(cmd.base) + (ADDR_W+1)'(cmd.len) > tail_q) begin
          tail_q <= (ADDR_W+1)'(cmd.base) + (ADDR_W+1)'(cmd.len);
        end
        last_def_vld_q <= 1'b0;
      end else if (is_del_w && cseg_ok_w) begin
        tab_q[cidx_w].vld <= 1'b0;
        if (del_last_w) begin
          tail_q         <= (ADDR_W+1)'(cent_w.base);
          last_def_vld_q <= 1'b0;
        end
      end
    end
  end

  // Active selection is dropped if its segment is deleted so stale data is not loaded.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_q        <= '0;
      active_vld_q <= 1'b0;
    end else if (ld_q == SWM_ST_IDLE) begin
      if (sel_ok_w) begin
        act_q        <= cidx_w;
        active_vld_q <= 1'b1;
      end else if (is_all_w || (is_del_w && cseg_ok_w && cidx_w == act_q)) begin
        active_vld_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Build defaults load during reset so the modes are right before the first command.
      legacy_q <= LEGACY_DEF;
      res12_q  <= RES12_DEF;
      err_q    <= 1'b0;
      busy_q   <= 1'b0;
    end else begin
      if (legacy_set) begin
        legacy_q <= legacy_val;
      end
      if (res_set) begin
        res12_q <= res12_val;
      end
      err_q  <= bad_cmd_w || ld_over_w || ld_short_w;
      busy_q <= ld_q != SWM_ST_IDLE;
    end
  end

  // Rate gate: a phase accumulator allows a fetch whenever it wraps past the clock rate.
  wire [SWM_DIV_W-1:0] rate_cap_w = legacy_q ? SWM_DIV_W'(SWM_RATE_LEG_SPS)
                                             : SWM_DIV_W'(SWM_RATE_MAX_SPS);
  wire [SWM_DIV_W-1:0] rate_w  = (rate_sps > rate_cap_w) ? rate_cap_w : rate_sps;
  wire [SWM_DIV_W:0]   phase_n = {1'b0, phase_q} + {1'b0, rate_w};
  wire                 tick_w  = phase_n >= (SWM_DIV_W+1)'(SWM_CLK_HZ);
  wire                 play_w  = out_en_q && active_vld_q && act_ent_w.vld && !busy_q;
  wire                 pb_end_w = pb_cnt_q + SWM_LEN_W'(1) >= act_ent_w.len;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_en_q   <= 1'b0;
      phase_q    <= '0;
      pb_addr_q  <= '0;
      pb_cnt_q   <= '0;
      wave_out   <= '0;
      wave_valid <= 1'b0;
      sync_out   <= 1'b0;
      dl_ready   <= 1'b0;
    end else begin
      out_en_q   <= out_en;
      dl_ready   <= f_ready_in && ld_q == SWM_ST_LOAD;
      wave_valid <= play_w && tick_w;
      if (!play_w || (out_en && !out_en_q)) begin
        phase_q   <= '0;
        pb_addr_q <= act_ent_w.base;
        pb_cnt_q  <= '0;
        sync_out  <= 1'b0;
      end else if (tick_w) begin
        phase_q  <= phase_n[SWM_DIV_W-1:0] - SWM_DIV_W'(SWM_CLK_HZ);
        wave_out <= mem_q[pb_addr_q];
        sync_out <= pb_cnt_q == '0;
        if (pb_end_w) begin
          pb_addr_q <= act_ent_w.base;
          pb_cnt_q  <= '0;
        end else begin
          pb_addr_q <= pb_addr_q + ADDR_W'(1);
          pb_cnt_q  <= pb_cnt_q + SWM_LEN_W'(1);
        end
      end else begin
        phase_q  <= phase_n[SWM_DIV_W-1:0];
        sync_out <= 1'b0;
      end
    end
  end

  // Command path checks.
  a_redefine_refused: assert property (@(posedge clk) disable iff (!rst_n)
    is_def_w && cseg_ok_w && cent_w.vld && ld_q == SWM_ST_IDLE |=> err_q)
    else $error("redefinition not flagged");
  a_load_needs_active: assert property (@(posedge clk) disable iff (!rst_n)
    is_load_w && !active_vld_q |=> err_q && ld_q == SWM_ST_IDLE)
    else $error("load accepted without active segment");
  a_gran_check: assert property (@(posedge clk) disable iff (!rst_n)
    is_def_w && !legacy_q && cmd.len[1] && ld_q == SWM_ST_IDLE |=> err_q)
    else $error("length not multiple of four accepted");
  a_delete_keeps_tail: assert property (@(posedge clk) disable iff (!rst_n)
    is_del_w && !del_last_w && !is_all_w && ld_q == SWM_ST_IDLE |=> $stable(tail_q))
    else $error("delete moved table end");
  a_clear_tail: assert property (@(posedge clk) disable iff (!rst_n)
    is_all_w && ld_q == SWM_ST_IDLE |=> tail_q == '0 && !active_vld_q)
    else $error("clear did not reset table");
  a_select_active: assert property (@(posedge clk) disable iff (!rst_n)
    sel_ok_w && ld_q == SWM_ST_IDLE |=> active_vld_q && act_q == $past(cidx_w))
    else $error("selection not taken");
  a_define_tail: assert property (@(posedge clk) disable iff (!rst_n)
    def_ok_w && ld_q == SWM_ST_IDLE |=> tail_q == $past(tail_q) + $past(cmd.len))
    else $error("define did not append at table end");
  a_delete_rewind: assert property (@(posedge clk) disable iff (!rst_n)
    del_last_w && ld_q == SWM_ST_IDLE |=> tail_q == (ADDR_W+1)'($past(cent_w.base)))
    else $error("delete of last segment did not rewind");
  a_delete_unlink: assert property (@(posedge clk) disable iff (!rst_n)
    is_del_w && cseg_ok_w && ld_q == SWM_ST_IDLE |=> !tab_q[$past(cidx_w)].vld)
    else $error("deleted segment still listed");
  a_table_entry: assert property (@(posedge clk) disable iff (!rst_n)
    tab_ok_w && ld_q == SWM_ST_IDLE |=> tab_q[$past(cidx_w)].vld)
    else $error("table entry not applied");
  a_legacy_set: assert property (@(posedge clk) disable iff (!rst_n)
    legacy_set |=> legacy_q == $past(legacy_val))
    else $error("legacy mode not switched");
  a_res_set: assert property (@(posedge clk) disable iff (!rst_n)
    res_set |=> res12_q == $past(res12_val))
    else $error("resolution not switched");

  // Download and playback path checks.
  a_load_start: assert property (@(posedge clk) disable iff (!rst_n)
    load_ok_w |=> ld_q == SWM_ST_LOAD)
    else $error("accepted load did not start");
  a_load_busy: assert property (@(posedge clk) disable iff (!rst_n)
    ld_q == SWM_ST_LOAD |=> busy_q)
    else $error("busy missing during download");
  a_ready_loading: assert property (@(posedge clk) disable iff (!rst_n)
    dl_ready |-> busy_q)
    else $error("download ready while idle");
  a_write_active: assert property (@(posedge clk) disable iff (!rst_n)
    ld_wr_w |-> active_vld_q)
    else $error("sample written without active segment");
  a_flush_idle: assert property (@(posedge clk) disable iff (!rst_n)
    ld_q == SWM_ST_IDLE |=> !f_valid)
    else $error("stale download data kept");
  a_short_err: assert property (@(posedge clk) disable iff (!rst_n)
    ld_short_w |=> err_q)
    else $error("short download not flagged");
  a_quiet_busy: assert property (@(posedge clk) disable iff (!rst_n)
    busy_q |=> !wave_valid)
    else $error("playback during download");
  a_sync_first: assert property (@(posedge clk) disable iff (!rst_n)
    sync_out |-> wave_valid)
    else $error("sync without sample");
  a_rate_cap: assert property (@(posedge clk) disable iff (!rst_n)
    legacy_q |-> rate_w <= SWM_DIV_W'(SWM_RATE_LEG_SPS))
    else $error("legacy rate cap broken");
  a_over_err: assert property (@(posedge clk) disable iff (!rst_n)
    ld_over_w |=> err_q ##1 ld_q == SWM_ST_IDLE)
    else $error("overlong download not flagged");
  a_widen: assert property (@(posedge clk) disable iff (!rst_n)
    res12_q && dl_valid |-> wide_w[SWM_LEGACY_SHL-1:0] == '0)
    else $error("legacy sample not shifted");

  c_define: cover property (@(posedge clk) disable iff (!rst_n) def_ok_w);
  c_load_done: cover property (@(posedge clk) disable iff (!rst_n) ld_end_w && !ld_short_w);
  c_play_wrap: cover property (@(posedge clk) disable iff (!rst_n) play_w && tick_w && pb_end_w);
  c_del_last: cover property (@(posedge clk) disable iff (!rst_n) del_last_w);
  c_short_load: cover property (@(posedge clk) disable iff (!rst_n) ld_short_w);
endmodule // swm_player

// ---- tb/swm_host_model.sv ----
// Host-side model that streams one download of consecutive samples.
`timescale 1ns/10ps
module swm_host_model
  import swm_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    start,
  input  wire logic [7:0]              count,
  input  wire logic [SWM_SAMPLE_W-1:0] first,
  input  wire logic                    dl_ready,
  output logic      [SWM_SAMPLE_W-1:0] dl_data,
  output logic                         dl_valid,
  output logic                         dl_last,
  output logic                         done
);
  logic [7:0] sent;

  initial begin
    dl_valid = 1'b0;
    dl_last  = 1'b0;
    dl_data  = 16'h0000;
    done     = 1'b0;
    sent     = 8'h00;
  end

  // The offer is held until dl_ready is seen high; a released bus shows the inverse value.
  always @(posedge clk) begin
    if (start) begin
      sent     <= 8'h00;
      dl_valid <= 1'b1;
      dl_data  <= first;
      dl_last  <= (count == 8'h01);
      done     <= 1'b0;
    end else if (dl_valid && dl_ready) begin
      if (dl_last) begin
        dl_valid <= 1'b0;
        dl_last  <= 1'b0;
        dl_data  <= ~dl_data;
        done     <= 1'b1;
      end else begin
        dl_data <= dl_data + 16'h0001;
        dl_last <= (sent + 8'h02 == count);
        sent    <= sent + 8'h01;
      end
    end
  end
endmodule // swm_host_model

// ---- tb/swm_player_bench.sv ----
// Self-checking bench for the segmented waveform player.
`timescale 1ns/10ps
module swm_player_bench
  import swm_pkg::*;
;
  logic                    clk, nrst, cmd_valid, out_en;
  swm_cmd_s                cmd;
  logic [SWM_SAMPLE_W-1:0] dl_data, wave_out, h_first;
  logic                    dl_valid, dl_last, dl_ready, wave_valid, sync_out;
  logic                    legacy_set, legacy_val, res_set, res12_val;
  logic                    err_q, legacy_q, res12_q, active_vld_q, busy_q;
  logic [SWM_DIV_W-1:0]    rate_sps;
  logic                    h_start, h_done;
  logic [7:0]              h_count;
  int                      mismatches, tests_run;

  swm_player #(.LEGACY_DEF(1'b1), .RES12_DEF(1'b1)) i_swm_player (
    .clk(clk), .nrst(nrst), .cmd(cmd), .cmd_valid(cmd_valid), .dl_data(dl_data),
    .dl_valid(dl_valid), .dl_last(dl_last), .legacy_set(legacy_set),
    .legacy_val(legacy_val), .res_set(res_set), .res12_val(res12_val),
    .rate_sps(rate_sps), .out_en(out_en), .dl_ready(dl_ready), .wave_out(wave_out),
    .wave_valid(wave_valid), .sync_out(sync_out), .err_q(err_q), .legacy_q(legacy_q),
    .res12_q(res12_q), .active_vld_q(active_vld_q), .busy_q(busy_q));

  swm_host_model i_swm_host_model (
    .clk(clk), .start(h_start), .count(h_count), .first(h_first), .dl_ready(dl_ready),
    .dl_data(dl_data), .dl_valid(dl_valid), .dl_last(dl_last), .done(h_done));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check_bit(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic timeout(input string what);
    mismatches++;
    $display("ERROR at %0t: timeout waiting for %s", $time, what);
    complete_run();
  endtask

  // Commands are spaced out so that each error pulse is tied to its own command.
  task automatic send_cmd(input swm_cmd_e c, input int seg, input int len, input logic exp_err);
    swm_cmd_s v;
    logic     seen;
    v      = '0;
    v.cmd  = c;
    v.seg  = seg[SWM_SEG_W:0];
    v.len  = len[SWM_LEN_W-1:0];
    v.base = '0;
    seen   = 1'b0;
    @(posedge clk);
    cmd       <= v;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    if (err_q === 1'b1) seen = 1'b1;
    repeat (3) begin
      @(posedge clk);
      #1;
      if (err_q === 1'b1) seen = 1'b1;
    end
    check_bit(seen, exp_err, "command refusal");
  endtask

  task automatic set_mode(input logic leg, input logic r12);
    @(posedge clk);
    legacy_set <= 1'b1;
    legacy_val <= leg;
    res_set    <= 1'b1;
    res12_val  <= r12;
    @(posedge clk);
    legacy_set <= 1'b0;
    res_set    <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check_bit(legacy_q, leg, "legacy mode");
    check_bit(res12_q, r12, "resolution");
  endtask

  task automatic load(input int n, input logic [15:0] first, input logic exp_err);
    int   k;
    logic seen;
    seen = 1'b0;
    send_cmd(SWM_CMD_LOAD, 0, 0, 1'b0);
    @(posedge clk);
    h_count <= n[7:0];
    h_first <= first;
    h_start <= 1'b1;
    @(posedge clk);
    h_start <= 1'b0;
    #1;
    for (k = 0; k < 300 && !(h_done === 1'b1 && busy_q === 1'b0); k++) begin
      @(posedge clk);
      #1;
      if (err_q === 1'b1) seen = 1'b1;
    end
    if (k == 300) timeout("download");
    repeat (3) begin
      @(posedge clk);
      #1;
      if (err_q === 1'b1) seen = 1'b1;
    end
    check_bit(seen, exp_err, "download count");
  endtask

  // Eight samples are awaited in turn, up to 50 clocks each, with sync expected on the first only.
  task automatic play(input logic [15:0] first, input logic shl);
    int          k;
    int          i;
    logic [15:0] e;
    @(posedge clk);
    out_en <= 1'b1;
    for (i = 0; i < 8; i++) begin
      k = 0;
      do begin
        @(posedge clk);
        #1;
        k++;
      end while (wave_valid !== 1'b1 && k < 50);
      if (k == 50) timeout("sample");
      e = first + i[15:0];
      if (shl) e = {e[11:0], 4'h0};
      check_word(wave_out, e, "played sample");
      check_bit(sync_out, i == 0, "sync marker");
    end
    @(posedge clk);
    out_en <= 1'b0;
  endtask

  task automatic t_reset();
    check_bit(legacy_q, 1'b1, "legacy default");
    check_bit(res12_q, 1'b1, "resolution default");
    check_bit(active_vld_q, 1'b0, "no active segment");
  endtask

  task automatic t_define();
    send_cmd(SWM_CMD_DEFINE, 0, 8, 1'b1);
    send_cmd(SWM_CMD_DEFINE, 3, 8, 1'b0);
    send_cmd(SWM_CMD_DEFINE, 1, 6, 1'b0);
    send_cmd(SWM_CMD_DEFINE, 2, 5, 1'b1);
    send_cmd(SWM_CMD_DEFINE, 3, 4, 1'b1);
    send_cmd(SWM_CMD_LOAD, 0, 0, 1'b1);
    send_cmd(SWM_CMD_SELECT, 9, 0, 1'b1);
  endtask

  task automatic t_play12();
    send_cmd(SWM_CMD_SELECT, 3, 0, 1'b0);
    check_bit(active_vld_q, 1'b1, "active segment");
    load(8, 16'h0A50, 1'b0);
    play(16'h0A50, 1'b1);
    send_cmd(SWM_CMD_SELECT, 1, 0, 1'b0);
    load(3, 16'h0111, 1'b1);
    send_cmd(SWM_CMD_SELECT, 3, 0, 1'b0);
    play(16'h0A50, 1'b1);
  endtask

  task automatic t_modern();
    set_mode(1'b0, 1'b0);
    send_cmd(SWM_CMD_DEFINE, 4, 6, 1'b1);
    send_cmd(SWM_CMD_DEFINE, 4, 8, 1'b0);
    send_cmd(SWM_CMD_DEFINE, 16384, 4, 1'b0);
    send_cmd(SWM_CMD_DEFINE, 16385, 4, 1'b1);
    send_cmd(SWM_CMD_SELECT, 4, 0, 1'b0);
    load(8, 16'hF0F0, 1'b0);
    play(16'hF0F0, 1'b0);
    load(8, 16'h1234, 1'b0);
    @(posedge clk);
    rate_sps <= 32'h00BEBC20;
    play(16'h1234, 1'b0);
  endtask

  task automatic t_table();
    send_cmd(SWM_CMD_DEL_ALL, 0, 0, 1'b0);
    send_cmd(SWM_CMD_SELECT, 3, 0, 1'b1);
    send_cmd(SWM_CMD_TABLE, 3, 8, 1'b0);
    send_cmd(SWM_CMD_SELECT, 3, 0, 1'b0);
    play(16'h0A50, 1'b1);
    send_cmd(SWM_CMD_DELETE, 3, 0, 1'b0);
    send_cmd(SWM_CMD_DEFINE, 5, 8, 1'b0);
    send_cmd(SWM_CMD_SELECT, 5, 0, 1'b0);
    load(8, 16'h0300, 1'b0);
    send_cmd(SWM_CMD_DELETE, 5, 0, 1'b0);
    check_bit(active_vld_q, 1'b0, "selection dropped");
    send_cmd(SWM_CMD_SELECT, 5, 0, 1'b1);
    send_cmd(SWM_CMD_DEFINE, 6, 8, 1'b0);
    send_cmd(SWM_CMD_SELECT, 6, 0, 1'b0);
    play(16'h0300, 1'b0);
  endtask

  initial begin
    nrst       = 1'b0;
    cmd        = '0;
    cmd_valid  = 1'b0;
    legacy_set = 1'b0;
    legacy_val = 1'b0;
    res_set    = 1'b0;
    res12_val  = 1'b0;
    rate_sps   = 32'h017D7840;
    out_en     = 1'b0;
    h_start    = 1'b0;
    h_count    = 8'h00;
    h_first    = 16'h0000;
    mismatches = 0;
    tests_run  = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    t_reset();
    t_define();
    t_play12();
    t_modern();
    t_table();
    complete_run();
  end
endmodule // swm_player_bench
